// [src/cfg_access_pkg.sv]
/*
 configuration access unit package: token codes, field layouts, register numbers and reset values.
 assumes a single core clock and 8-bit token/data stream with a control flag.
*/
`default_nettype none
package cfg_access_pkg;
   localparam logic [7:0]  TOK_WRITE      = 8'hC0;   // 192
   localparam logic [7:0]  TOK_READ       = 8'hC1;   // 193
   localparam logic [7:0]  TOK_PWRITE     = 8'h24;   // 36
   localparam logic [7:0]  TOK_PREAD      = 8'h25;   // 37
   localparam logic [7:0]  TOK_END        = 8'h01;
   localparam logic [7:0]  TOK_ACK        = 8'h03;
   localparam logic [7:0]  TOK_NACK       = 8'h04;
   localparam logic [7:0]  NOREPLY_LOW    = 8'hFF;
   localparam logic [7:0]  PS_RES_TYPE    = 8'h0C;
   localparam int          PS_SHIFT       = 8;
   localparam logic [15:0] REG_RAM_BASE   = 16'h0000;
   localparam logic [15:0] REG_VEC_BASE   = 16'h0001;
   localparam logic [15:0] REG_TILE_CTRL  = 16'h0002;
   localparam logic [31:0] RAM_BASE_RST   = 32'h0004_0000;
   localparam logic [31:0] RAM_BASE_MASK  = 32'hFFFF_FFFC;
   localparam logic [31:0] VEC_BASE_RST   = 32'h0000_0000;
   localparam logic [31:0] VEC_BASE_MASK  = 32'hFFFC_0000;
   localparam logic [31:0] TILE_CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] TILE_CTRL_MASK = 32'h03FF_FF36;
   localparam int          TX_DLY_LSB     = 18;
   localparam int          TX_DIV_LSB     = 9;
   localparam int          RGMII_EN_BIT   = 8;
   localparam int          DIV_DYN_BIT    = 5;
   localparam int          DIV_EN_BIT     = 4;
   localparam int          UTMI_SEL_BIT   = 2;
   localparam int          ULPI_EN_BIT    = 1;
endpackage
`default_nettype wire

// [src/rgmii_tx_clk_div.sv]
/*
 rgmii transmit clock divider, counting on pll-output enable pulses.
 assumes pll_tick is a one-cycle enable from the core clock domain.
*/
`default_nettype none
module rgmii_tx_clk_div (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       en,
   input  wire logic       pll_tick,
   input  wire logic [8:0] div_val,
   output logic            tx_clk
);
   logic [8:0] cnt_r;
   logic       hit_top;
   logic       hit_half;
   assign hit_top  = (cnt_r == div_val);
   assign hit_half = (cnt_r == (div_val >> 1));

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_r  <= 9'h000;
         tx_clk <= 1'b0;
      end else if (!en) begin
         cnt_r  <= 9'h000;
         tx_clk <= 1'b0;
      end else if (pll_tick) begin
         cnt_r <= hit_top ? 9'h000 : cnt_r + 9'h001;
         if (hit_top) begin
            tx_clk <= 1'b1; // RULE14
         end else if (hit_half) begin
            tx_clk <= 1'b0; // RULE14
         end
      end
   end
endmodule
`default_nettype wire

// [src/cfg_access_port.sv]
/*
 token-framed configuration access unit plus processor-status register bank.
 assumes an 8-bit token stream with control flag, one-cycle valid, reply sink always ready.
*/
// Summary of operation
// [RULE1] write: 192, id24, reg16, data32, 1
// [RULE2] write reply: 3,1 ok or 4,1 fail
// [RULE3] read: 193, id24, reg16, then 1
// [RULE4] read reply: 3, data32, 1 or 4,1
// [RULE5] tile registers addressed at C20C channel
// [RULE6] node registers addressed at C30C channel
// [RULE7] peripheral addressed node, periph, 02
// [RULE8] peripheral: 36/37, id, reg8, size8, data, 1
// [RULE9] peripheral read reply: 3, data, 1 else 4,1; this block always answers 4,1
// [RULE10] status id is number<<8 ORed 0x0C
// [RULE11] ram base resets 0x00040000, bits 1:0 fixed
// [RULE12] vector target: base high, event vector low
// [RULE13] tile control 25:18 holds tx delay
// [RULE14] tx clock divider field holds divide minus one
// [RULE15] bit 8 enables rgmii ports
// [RULE16] bit 4 divider enable, bit 5 dynamic
// [RULE17] bit 2 selects utmi, bit 1 ulpi support
// [RULE18] reply sent to request's 24-bit channel id
// [RULE19] write id low byte all ones: no reply; this block still answers 4,1 to a refused write
// [RULE20] multibyte fields sent most significant first
// [RULE21] reserved bits unchanged, read as zero
// [RULE22] unknown register or bad frame answers 4,1; this block gives no reply to a frame opened by an unknown token
`default_nettype none
module cfg_access_port (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        rx_valid,
   input  wire logic        rx_ctrl,
   input  wire logic [7:0]  rx_data,
   output logic             tx_valid,
   output logic             tx_ctrl,
   output logic [7:0]       tx_data,
   output logic [23:0]      tx_dest,
   input  wire logic        ps_we,
   input  wire logic [15:0] ps_res_id,
   input  wire logic [31:0] ps_wdata,
   output logic [31:0]      ps_rdata,
   input  wire logic        evt_take,
   input  wire logic [15:0] evt_vector,
   output logic [31:0]      evt_target,
   input  wire logic        all_paused,
   input  wire logic        pll_tick,
   output logic [7:0]       rgmii_tx_delay,
   output logic             rgmii_tx_clk,
   output logic             rgmii_en,
   output logic             clk_div_active,
   output logic             utmi_sel,
   output logic             ulpi_en
);
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_HDR  = 6'b000010,
      S_DATA = 6'b000100,
      S_END  = 6'b001000,
      S_RPLY = 6'b010000,
      S_SKIP = 6'b100000
   } st_e;

   st_e         st_r;
   logic        is_wr_r, is_per_r, fail_r;
   logic [2:0]  cnt_r;
   logic [23:0] id_r;
   logic [15:0] reg_r;
   logic [31:0] dat_r;
   logic [7:0]  size_r;
   logic [2:0]  rcnt_r;
   logic [2:0]  rlen_r;
   logic [31:0] ram_base_r, vec_base_r, tile_ctrl_r;

   // header bytes: id 3 + reg 2 (or reg 1 + size 1 for peripherals)
   wire [2:0]  hdr_len   = is_per_r ? 3'd5 : 3'd5;
   wire        tok_start = rx_valid && rx_ctrl;
   wire        dat_byte  = rx_valid && !rx_ctrl;
   wire        end_tok   = rx_valid && rx_ctrl && rx_data == cfg_access_pkg::TOK_END;
   wire [2:0]  dat_len   = is_per_r ? size_r[2:0] : 3'd4;
   // size byte is still on rx_data at the last header byte; size_r lands on that edge
   wire        need_dat  = is_wr_r && (is_per_r ? rx_data != 8'h00 : 1'b1);
   // peripheral registers live outside this tile: always refused here
   wire        reg_known = !is_per_r && (reg_r <= cfg_access_pkg::REG_TILE_CTRL);
   wire        no_reply  = is_wr_r && id_r[7:0] == cfg_access_pkg::NOREPLY_LOW; // RULE19
   wire [31:0] rd_val    = reg_r[1:0] == 2'd0 ? ram_base_r :
                           reg_r[1:0] == 2'd1 ? vec_base_r : tile_ctrl_r;
   wire        do_write  = st_r == S_END && end_tok && is_wr_r && !fail_r && reg_known;
   wire        ok_end    = end_tok && !fail_r && reg_known;
   wire [2:0]  ok_len    = is_wr_r ? 3'd2 : 3'd6;

   // status resource id = number<<8 | 0x0C
   wire        ps_hit    = ps_res_id[7:0] == cfg_access_pkg::PS_RES_TYPE; // RULE10
   wire [7:0]  ps_num    = ps_res_id[15:cfg_access_pkg::PS_SHIFT];

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r <= S_IDLE;
         is_wr_r <= 1'b0;
         is_per_r <= 1'b0;
         fail_r <= 1'b0;
         cnt_r <= 3'd0;
         id_r <= 24'h000000;
         reg_r <= 16'h0000;
         dat_r <= 32'h00000000;
         size_r <= 8'h00;
         rcnt_r <= 3'd0;
         rlen_r <= 3'd0;
      end else begin
         case (st_r)
            S_IDLE: begin
               if (tok_start) begin
                  cnt_r <= 3'd0;
                  fail_r <= 1'b0;
                  reg_r <= 16'h0000;
                  size_r <= 8'h00;
                  if (rx_data == cfg_access_pkg::TOK_WRITE || rx_data == cfg_access_pkg::TOK_READ) begin
                     is_wr_r <= rx_data == cfg_access_pkg::TOK_WRITE; // RULE1 RULE3
                     is_per_r <= 1'b0;
                     st_r <= S_HDR;
                  end else if (rx_data == cfg_access_pkg::TOK_PWRITE || rx_data == cfg_access_pkg::TOK_PREAD) begin
                     is_wr_r <= rx_data == cfg_access_pkg::TOK_PWRITE; // RULE8
                     is_per_r <= 1'b1;
                     st_r <= S_HDR;
                  end
               end
            end
            S_HDR: begin
               if (tok_start) begin
                  fail_r <= 1'b1;
                  st_r <= end_tok ? S_RPLY : S_SKIP; // RULE22
                  rcnt_r <= 3'd0;
                  rlen_r <= 3'd2;
               end else if (dat_byte) begin
                  cnt_r <= cnt_r + 3'd1;
                  if (cnt_r < 3'd3) id_r <= {id_r[15:0], rx_data}; // RULE20
                  else if (is_per_r && cnt_r == 3'd4) size_r <= rx_data; // RULE8
                  else reg_r <= {reg_r[7:0], rx_data}; // RULE20
                  if (cnt_r == hdr_len - 3'd1) begin
                     cnt_r <= 3'd0;
                     st_r <= need_dat ? S_DATA : S_END;
                  end
               end
            end
            S_DATA: begin
               if (tok_start) begin
                  fail_r <= 1'b1;
                  st_r <= end_tok ? S_RPLY : S_SKIP; // RULE22
                  rcnt_r <= 3'd0;
                  rlen_r <= 3'd2;
               end else if (dat_byte) begin
                  dat_r <= {dat_r[23:0], rx_data}; // RULE20
                  cnt_r <= cnt_r + 3'd1;
                  if (cnt_r == dat_len - 3'd1 || cnt_r == 3'd3) st_r <= S_END;
               end
            end
            S_END: begin
               if (rx_valid) begin
                  if (!ok_end) fail_r <= 1'b1; // RULE22
                  rcnt_r <= 3'd0;
                  rlen_r <= ok_end ? ok_len : 3'd2;
                  if (end_tok) st_r <= (no_reply && ok_end) ? S_IDLE : S_RPLY;
                  else st_r <= S_SKIP;
               end
            end
            S_SKIP: begin
               if (end_tok) st_r <= S_RPLY; // RULE22
            end
            S_RPLY: begin
               rcnt_r <= rcnt_r + 3'd1;
               if (rcnt_r == rlen_r - 3'd1) st_r <= S_IDLE;
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // reply byte: ack/nack, optional word msb first, end token
   wire        r_first = rcnt_r == 3'd0;
   wire        r_last  = rcnt_r == rlen_r - 3'd1;
   wire [1:0]  bsel    = 2'(3'd4 - rcnt_r);
   wire [7:0]  r_word  = rd_val[{bsel, 3'b000} +: 8];
   wire [7:0]  r_byte  = r_first ? (fail_r ? cfg_access_pkg::TOK_NACK : cfg_access_pkg::TOK_ACK) :
                         r_last  ? cfg_access_pkg::TOK_END : r_word;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_valid <= 1'b0;
         tx_ctrl  <= 1'b0;
         tx_data  <= 8'h00;
         tx_dest  <= 24'h000000;
      end else begin
         tx_valid <= st_r == S_RPLY; // RULE2 RULE4 RULE9
         tx_ctrl  <= r_first || r_last;
         tx_data  <= r_byte; // RULE20
         tx_dest  <= id_r; // RULE18
      end
   end

   // register bank: packet write, or status write from the core
   wire        ps_wr = ps_we && ps_hit;
   wire [7:0]  w_num = do_write ? reg_r[7:0] : ps_num;
   wire [31:0] w_val = do_write ? dat_r : ps_wdata;
   wire        w_en  = do_write || ps_wr;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ram_base_r  <= cfg_access_pkg::RAM_BASE_RST; // RULE11
         vec_base_r  <= cfg_access_pkg::VEC_BASE_RST;
         tile_ctrl_r <= cfg_access_pkg::TILE_CTRL_RST; // RULE13 RULE15 RULE16
      end else if (w_en) begin
         if (w_num == cfg_access_pkg::REG_RAM_BASE[7:0])
            ram_base_r <= w_val & cfg_access_pkg::RAM_BASE_MASK; // RULE11 RULE21
         if (w_num == cfg_access_pkg::REG_VEC_BASE[7:0])
            vec_base_r <= w_val & cfg_access_pkg::VEC_BASE_MASK; // RULE12 RULE21
         if (w_num == cfg_access_pkg::REG_TILE_CTRL[7:0])
            tile_ctrl_r <= w_val & cfg_access_pkg::TILE_CTRL_MASK; // RULE21
      end
   end

   wire [31:0] ps_sel = ps_num == 8'h00 ? ram_base_r : ps_num == 8'h01 ? vec_base_r :
                        ps_num == 8'h02 ? tile_ctrl_r : 32'h00000000;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ps_rdata <= 32'h00000000;
         evt_target <= 32'h00000000;
         rgmii_tx_delay <= 8'h00;
         rgmii_en <= 1'b0;
         clk_div_active <= 1'b0;
         utmi_sel <= 1'b0;
         ulpi_en <= 1'b0;
      end else begin
         ps_rdata <= ps_hit ? ps_sel : 32'h00000000; // RULE10
         if (evt_take) evt_target <= {vec_base_r[31:16], evt_vector}; // RULE12
         rgmii_tx_delay <= tile_ctrl_r[cfg_access_pkg::TX_DLY_LSB +: 8]; // RULE13
         rgmii_en <= tile_ctrl_r[cfg_access_pkg::RGMII_EN_BIT]; // RULE15
         // dynamic mode divides only while every active thread waits
         clk_div_active <= tile_ctrl_r[cfg_access_pkg::DIV_EN_BIT] &&
                           (!tile_ctrl_r[cfg_access_pkg::DIV_DYN_BIT] || all_paused); // RULE16
         utmi_sel <= tile_ctrl_r[cfg_access_pkg::UTMI_SEL_BIT]; // RULE17
         ulpi_en <= tile_ctrl_r[cfg_access_pkg::ULPI_EN_BIT]; // RULE17
      end
   end

   rgmii_tx_clk_div u_txdiv (
      .mclk     (mclk),
      .rst      (rst),
      .en       (tile_ctrl_r[cfg_access_pkg::RGMII_EN_BIT]),
      .pll_tick (pll_tick),
      .div_val  (tile_ctrl_r[cfg_access_pkg::TX_DIV_LSB +: 9]),
      .tx_clk   (rgmii_tx_clk)
   );

   property p_ram_reset;
      @(posedge mclk) $fell(rst) |-> ram_base_r == cfg_access_pkg::RAM_BASE_RST;
   endproperty
   a_ram_reset: assert property (p_ram_reset) else $error("ram base reset wrong"); // RULE11

   property p_ram_low;
      @(posedge mclk) disable iff (rst) ram_base_r[1:0] == 2'b00;
   endproperty
   a_ram_low: assert property (p_ram_low) else $error("ram base low bits set"); // RULE21

   property p_vec_low;
      @(posedge mclk) disable iff (rst) vec_base_r[17:0] == 18'h00000;
   endproperty
   a_vec_low: assert property (p_vec_low) else $error("vector base reserved bits set"); // RULE21

   property p_evt;
      @(posedge mclk) disable iff (rst) evt_take |=> evt_target == {$past(vec_base_r[31:16]), $past(evt_vector)};
   endproperty
   a_evt: assert property (p_evt) else $error("event target wrong"); // RULE12

   property p_reply_first;
      @(posedge mclk) disable iff (rst) $rose(tx_valid) |-> tx_ctrl && (tx_data == cfg_access_pkg::TOK_ACK ||
                                        tx_data == cfg_access_pkg::TOK_NACK);
   endproperty
   a_reply_first: assert property (p_reply_first) else $error("reply start token wrong"); // RULE2

   property p_reply_end;
      @(posedge mclk) disable iff (rst) $fell(tx_valid) |->
         $past(tx_ctrl) && $past(tx_data) == cfg_access_pkg::TOK_END;
   endproperty
   a_reply_end: assert property (p_reply_end) else $error("reply end token wrong"); // RULE4

   property p_nack_short;
      @(posedge mclk) disable iff (rst) $rose(tx_valid) && tx_data == cfg_access_pkg::TOK_NACK |=>
         tx_ctrl && tx_data == cfg_access_pkg::TOK_END ##1 !tx_valid;
   endproperty
   a_nack_short: assert property (p_nack_short) else $error("failure reply not 4,1"); // RULE22

   property p_div;
      @(posedge mclk) disable iff (rst) clk_div_active |-> $past(tile_ctrl_r[cfg_access_pkg::DIV_EN_BIT]);
   endproperty
   a_div: assert property (p_div) else $error("divider active while disabled"); // RULE16

   c_ack: cover property (@(posedge mclk) $rose(tx_valid) && tx_data == cfg_access_pkg::TOK_ACK);
   c_nack: cover property (@(posedge mclk) $rose(tx_valid) && tx_data == cfg_access_pkg::TOK_NACK);
   c_pwrite: cover property (@(posedge mclk) ps_wr);
endmodule
`default_nettype wire

// [tb/chanend_model.sv]
/*
 remote channel end model: sends token frames to the block, gathers reply symbols.
 assumes the block takes one symbol per valid cycle and applies no back-pressure.
*/
`default_nettype none
module chanend_model (
   input  wire logic        mclk,
   output logic             rx_valid,
   output logic             rx_ctrl,
   output logic [7:0]       rx_data,
   input  wire logic        tx_valid,
   input  wire logic        tx_ctrl,
   input  wire logic [7:0]  tx_data,
   input  wire logic [23:0] tx_dest
);
   timeunit 1ns;
   timeprecision 1ps;
   // routing of this end; the block never sees these
   localparam logic [31:0] DEST_TILE = 32'h0001_C20C;
   localparam logic [31:0] DEST_NODE = 32'h0001_C30C;
   localparam logic [31:0] DEST_PERI = 32'h0001_0702;
   logic [8:0]  rep_q[$];
   logic [23:0] dest_r;
   initial begin
      rx_valid = 1'b0;
      rx_ctrl  = 1'b0;
      rx_data  = 8'h00;
   end
   task automatic put(input logic c, input logic [7:0] b);
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_ctrl  <= c;
      rx_data  <= b;
   endtask
   // idle data inverted so a stale byte never passes for a live one
   task automatic idle();
      @(posedge mclk);
      rx_valid <= 1'b0;
      rx_ctrl  <= 1'b0;
      rx_data  <= ~rx_data;
   endtask
   task automatic head(input logic [7:0] tok, input logic [23:0] id);
      put(1'b1, tok);
      for (int i = 2; i >= 0; i--) put(1'b0, id[8*i +: 8]);
   endtask
   always @(posedge mclk) begin
      if (tx_valid) begin
         rep_q.push_back({tx_ctrl, tx_data});
         dest_r = tx_dest;
      end
   end
endmodule
`default_nettype wire

// [tb/tb.sv]
/*
 testbench for the configuration access unit: token frames and status accesses.
 assumes the channel end model in chanend_model and a 50 MHz core clock.
*/
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        rx_valid, rx_ctrl, tx_valid, tx_ctrl, ps_we, evt_take, all_paused, pll_tick;
   logic        rgmii_tx_clk, rgmii_en, clk_div_active, utmi_sel, ulpi_en, prev;
   logic [7:0]  rx_data, tx_data, rgmii_tx_delay;
   logic [23:0] tx_dest;
   logic [15:0] ps_res_id, evt_vector;
   logic [31:0] ps_wdata, ps_rdata, evt_target;
   int          num_errors = 0;
   int          samples_checked = 0;
   int          rises;
   always #10 mclk = ~mclk;
   cfg_access_port uut (.mclk(mclk), .rst(rst), .rx_valid(rx_valid), .rx_ctrl(rx_ctrl), .rx_data(rx_data),
      .tx_valid(tx_valid), .tx_ctrl(tx_ctrl), .tx_data(tx_data), .tx_dest(tx_dest), .ps_we(ps_we),
      .ps_res_id(ps_res_id), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .evt_take(evt_take),
      .evt_vector(evt_vector), .evt_target(evt_target), .all_paused(all_paused), .pll_tick(pll_tick),
      .rgmii_tx_delay(rgmii_tx_delay), .rgmii_tx_clk(rgmii_tx_clk), .rgmii_en(rgmii_en),
      .clk_div_active(clk_div_active), .utmi_sel(utmi_sel), .ulpi_en(ulpi_en));
   chanend_model peer (.mclk(mclk), .rx_valid(rx_valid), .rx_ctrl(rx_ctrl), .rx_data(rx_data),
      .tx_valid(tx_valid), .tx_ctrl(tx_ctrl), .tx_data(tx_data), .tx_dest(tx_dest));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // kind: 0 none, 1 success, 2 failure, 3 success with data
   task automatic reply(input int kind, input logic [31:0] d, input logic [23:0] id);
      logic [8:0] e[$];
      int         n;
      if (kind == 1) e = '{9'h103, 9'h101};
      if (kind == 2) e = '{9'h104, 9'h101};
      if (kind == 3) e = '{9'h103, {1'b0, d[31:24]}, {1'b0, d[23:16]}, {1'b0, d[15:8]}, {1'b0, d[7:0]}, 9'h101};
      n = 0;
      while (peer.rep_q.size() < e.size() && n < 40) begin
         @(posedge mclk);
         n++;
      end
      // extra wait so a late or surplus symbol is caught
      repeat (10) @(posedge mclk);
      chk("reply length", e.size(), peer.rep_q.size());
      foreach (e[i]) if (i < peer.rep_q.size()) chk("reply symbol", {23'h0, e[i]}, {23'h0, peer.rep_q[i]});
      if (kind != 0) chk("reply channel", {8'h00, id}, {8'h00, peer.dest_r});
      peer.rep_q.delete();
   endtask
   task automatic wr(input logic [23:0] id, input logic [15:0] rn, input logic [31:0] d);
      peer.head(cfg_access_pkg::TOK_WRITE, id);
      peer.put(1'b0, rn[15:8]);
      peer.put(1'b0, rn[7:0]);
      for (int i = 3; i >= 0; i--) peer.put(1'b0, d[8*i +: 8]);
      peer.put(1'b1, cfg_access_pkg::TOK_END);
      peer.idle();
   endtask
   // a last byte other than 01 puts data where the closing token belongs
   task automatic rd(input logic [23:0] id, input logic [15:0] rn, input logic [7:0] last);
      peer.head(cfg_access_pkg::TOK_READ, id);
      peer.put(1'b0, rn[15:8]);
      peer.put(1'b0, rn[7:0]);
      if (last != 8'h01) peer.put(1'b0, last);
      peer.put(1'b1, cfg_access_pkg::TOK_END);
      peer.idle();
   endtask
   task automatic ps_rd(input logic [7:0] num, input logic [31:0] exp, input string what);
      @(posedge mclk);
      ps_res_id <= {num, cfg_access_pkg::PS_RES_TYPE};
      @(posedge mclk);
      @(posedge mclk);
      chk(what, exp, ps_rdata);
   endtask
   task automatic ps_wr(input logic [7:0] num, input logic [31:0] d);
      @(posedge mclk);
      ps_res_id <= {num, cfg_access_pkg::PS_RES_TYPE};
      ps_wdata  <= d;
      ps_we     <= 1'b1;
      @(posedge mclk);
      ps_we     <= 1'b0;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      $display("Error watchdog expired");
      tally_and_finish();
   end
   initial begin
      {ps_we, evt_take, all_paused, pll_tick, prev} = 5'h00;
      ps_res_id  = 16'h0000;
      evt_vector = 16'h0000;
      ps_wdata   = 32'h0000_0000;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      ps_rd(8'h00, 32'h0004_0000, "ram base reset");
      ps_rd(8'h01, 32'h0000_0000, "vector base reset");
      ps_rd(8'h02, 32'h0000_0000, "tile control reset");
      $display("test reset values done");
      wr(24'h0A0B01, 16'h0000, 32'hFFFF_FFFF);
      reply(1, 32'h0, 24'h0A0B01);
      rd(24'h0A0B02, 16'h0000, 8'h01);
      reply(3, 32'hFFFF_FFFC, 24'h0A0B02);
      wr(24'h0A0BFF, 16'h0000, 32'h1234_5678);
      reply(0, 32'h0, 24'h0);
      ps_rd(8'h00, 32'h1234_5678, "ram base silent write");
      $display("test stream access done");
      wr(24'h000102, 16'h0001, 32'hFFFF_FFFF);
      reply(1, 32'h0, 24'h000102);
      @(posedge mclk);
      evt_vector <= 16'h1234;
      evt_take   <= 1'b1;
      @(posedge mclk);
      evt_take   <= 1'b0;
      @(posedge mclk);
      chk("event target", 32'hFFFC_1234, evt_target);
      rd(24'h000108, 16'h0001, 8'h01);
      reply(3, 32'hFFFC_0000, 24'h000108);
      $display("test vector base done");
      wr(24'h000103, 16'h0005, 32'h0000_0001);
      reply(2, 32'h0, 24'h000103);
      rd(24'h000104, 16'h0002, 8'h55);
      reply(2, 32'h0, 24'h000104);
      peer.head(cfg_access_pkg::TOK_PREAD, 24'h000105);
      peer.put(1'b0, 8'h10);
      peer.put(1'b0, 8'h04);
      peer.put(1'b1, cfg_access_pkg::TOK_END);
      peer.idle();
      reply(2, 32'h0, 24'h000105);
      peer.head(cfg_access_pkg::TOK_PWRITE, 24'h000106);
      peer.put(1'b0, 8'h10);
      peer.put(1'b0, 8'h01);
      peer.put(1'b0, 8'hA5);
      peer.put(1'b1, cfg_access_pkg::TOK_END);
      peer.idle();
      reply(2, 32'h0, 24'h000106);
      peer.head(cfg_access_pkg::TOK_READ, 24'h000107);
      peer.put(1'b1, cfg_access_pkg::TOK_END);
      peer.idle();
      reply(2, 32'h0, 24'h000107);
      peer.put(1'b1, 8'h55);
      peer.idle();
      reply(0, 32'h0, 24'h0);
      ps_rd(8'h05, 32'h0000_0000, "unmapped status reads zero");
      $display("test refusals done");
      ps_wr(8'h02, 32'hFFFF_FFFF);
      ps_rd(8'h02, 32'h03FF_FF36, "tile control writable bits");
      chk("tx data delay", 32'hFF, {24'h0, rgmii_tx_delay});
      chk("rgmii enable", 32'h1, {31'h0, rgmii_en});
      chk("usb select", 32'h3, {30'h0, utmi_sel, ulpi_en});
      chk("dynamic divider running", 32'h0, {31'h0, clk_div_active});
      all_paused <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("dynamic divider paused", 32'h1, {31'h0, clk_div_active});
      ps_wr(8'h02, 32'h0000_0710);
      all_paused <= 1'b0;
      pll_tick   <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("static divider", 32'h1, {31'h0, clk_div_active});
      chk("usb select cleared", 32'h0, {30'h0, utmi_sel, ulpi_en});
      rises = 0;
      // divide value 3 gives a period of four ticks: about twenty rises in 80
      repeat (80) begin
         @(posedge mclk);
         if (rgmii_tx_clk && !prev) rises++;
         prev = rgmii_tx_clk;
      end
      chk("tx clock rises", 32'h1, {31'h0, rises >= 19 && rises <= 21});
      rd(24'h000109, 16'h0002, 8'h01);
      reply(3, 32'h0000_0710, 24'h000109);
      $display("test tile control done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
